// *** core/mov_exec_pkg.sv ***
// constants, opcodes and register map of the byte move / multiply load executor
package mov_exec_pkg;

	localparam int WORD_W   = 16;
	localparam int TAG_BIT  = 16;
	localparam int ACC_NUM  = 8;
	localparam int ACC_IW   = 3;
	localparam int IDX_NUM  = 8;

	// opcode field, instruction bits 16..10
	localparam logic [6:0] OP_MAC_LOAD     = 7'h34;
	localparam logic [6:0] OP_MAC_LOAD_STR = 7'h35;
	localparam logic [6:0] OP_BYTE_LOAD    = 7'h26;
	localparam logic [6:0] OP_BYTE_STORE   = 7'h28;
	localparam logic [6:0] OP_BSTR_LOAD    = 7'h27;
	localparam logic [6:0] OP_BSTR_STORE   = 7'h29;
	localparam logic [6:0] OP_BYTE_ACC_IMM = 7'h51;
	localparam logic [6:0] OP_BYTE_MR_IMM  = 7'h57;
	// bits 16..11 for the index register immediate form
	localparam logic [5:0] OP_BYTE_IDX_IMM = 6'h2E;

	// addressing form, operand field bits 7..6
	localparam logic [1:0] AM_DIRECT   = 2'h0;
	localparam logic [1:0] AM_LONG_REL = 2'h1;
	localparam logic [1:0] AM_INDIRECT = 2'h2;
	localparam logic [1:0] AM_REG_REL  = 2'h3;

	localparam logic [15:0] LEN_SHORT = 16'h0001;
	localparam logic [15:0] LEN_LONG  = 16'h0002;

	// register byte offsets
	localparam logic [6:0] OFS_CTRL   = 7'h00;
	localparam logic [6:0] OFS_STATUS = 7'h04;
	localparam logic [6:0] OFS_PC     = 7'h08;
	localparam logic [6:0] OFS_MR     = 7'h0C;
	localparam logic [6:0] OFS_PH     = 7'h10;
	localparam logic [6:0] OFS_ACC0   = 7'h20;
	localparam logic [6:0] OFS_IDX0   = 7'h40;

	// control fields
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_LEN_LSB = 4;
	localparam int CTRL_LEN_W   = 3;

	// status fields
	localparam int ST_TAG   = 0;
	localparam int ST_OV    = 1;
	localparam int ST_SIGN  = 2;
	localparam int ST_ZERO  = 3;
	localparam int ST_CARRY = 4;
	localparam int ST_RCF   = 5;
	localparam int ST_RZF   = 6;
	localparam int ST_XSF   = 7;
	localparam int ST_XZF   = 8;
	localparam int ST_BUSY  = 9;
	localparam int ST_ILL   = 10;

	localparam logic [15:0] PC_RESET      = 16'h0000;
	localparam logic [2:0]  STR_LEN_RESET = 3'h1;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'b0000001,
		ST_FETCH  = 7'b0000010,
		ST_DECODE = 7'b0000100,
		ST_EXT    = 7'b0001000,
		ST_ADDR   = 7'b0010000,
		ST_MEM    = 7'b0100000,
		ST_DONE   = 7'b1000000
	} exec_state_t;

endpackage

// *** core/operand_address_gen.sv ***
// forms the data memory byte address of a memory operand
`timescale 1ns/1ps
module operand_address_gen (
	input  wire logic [7:0]       adrs_in,
	input  wire logic [15:0]      ext_word_in,
	input  wire logic [7:0][15:0] idx_in,
	output logic      [15:0]      addr_out,
	output logic                  needs_ext_out
);
	logic [1:0] mode;
	logic [2:0] sel_a;
	logic [2:0] sel_b;

	assign mode  = adrs_in[7:6];
	assign sel_a = adrs_in[5:3];
	assign sel_b = adrs_in[2:0];

	always_comb begin
		addr_out      = 16'h0000;
		needs_ext_out = 1'b0;
		case (mode)
			mov_exec_pkg::AM_DIRECT: begin
				addr_out      = ext_word_in;
				needs_ext_out = 1'b1;
			end
			mov_exec_pkg::AM_LONG_REL: begin
				addr_out      = idx_in[sel_b] + ext_word_in;
				needs_ext_out = 1'b1;
			end
			mov_exec_pkg::AM_INDIRECT: begin
				addr_out = idx_in[sel_b];
			end
			mov_exec_pkg::AM_REG_REL: begin
				addr_out = idx_in[sel_a] + idx_in[sel_b];
			end
			default: begin
				addr_out = 16'h0000;
			end
		endcase
	end
endmodule // operand_address_gen

// *** core/byte_move_and_mac_load_exec.sv ***
// executor for byte moves, byte string moves and multiply operand loads with add
`timescale 1ns/1ps
module byte_move_and_mac_load_exec (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_in,
	input  wire logic [6:0]  avs_address_in,
	input  wire logic        avs_read_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	output logic      [31:0] avs_readdata_out,
	output logic             avs_waitrequest_out,
	output logic             prog_rd_out,
	output logic      [15:0] prog_addr_out,
	input  wire logic [16:0] prog_data_in,
	input  wire logic        prog_ack_in,
	output logic             dmem_req_out,
	output logic             dmem_we_out,
	output logic      [15:0] dmem_addr_out,
	output logic      [7:0]  dmem_wdata_out,
	input  wire logic [16:0] dmem_rdata_in,
	input  wire logic        dmem_ack_in
);
	mov_exec_pkg::exec_state_t state_q;
	logic [15:0]                pc_q;
	logic [16:0]                instr_q;
	logic [15:0]                ext_q;
	logic [2:0]                 cnt_q;
	logic                       run_q;
	logic [2:0]                 str_len_q;
	logic [15:0]                prog_addr_q;
	logic [15:0]                dmem_addr_q;
	logic [7:0]                 dmem_wdata_q;
	logic [15:0]                accumulator_n_q [mov_exec_pkg::ACC_NUM];
	logic [15:0]                multiplier_operand_reg_q;
	logic [15:0]                product_high_reg_q;
	logic [7:0][15:0]           idx_q;
	logic                       tag_flag_q, overflow_flag_q, sign_flag_q;
	logic                       zero_flag_q, carry_flag_q, aux_reg_carry_flag_q;
	logic                       aux_reg_zero_flag_q, ext_sign_flag_q, ext_zero_flag_q;
	logic                       illegal_q;
	logic                       bus_ack_q;
	logic [31:0]                rdata_q;

	localparam int ACC_IW_L = mov_exec_pkg::ACC_IW;
	logic [6:0]  opcode;
	logic [1:0]  an;
	logic [7:0]  imm8;
	logic [7:0]  idx_imm;
	logic [2:0]  idx_sel;
	logic        is_maph, is_maphs, is_bld, is_bst, is_bsld, is_bsst;
	logic        is_acc_imm, is_mr_imm, is_idx_imm, is_mem, is_str;
	logic        needs_ext;
	logic [15:0] op_addr;
	logic [15:0] instr_len;
	logic        mem_done;
	logic        last_elem;
	logic [ACC_IW_L-1:0] acc_base;
	logic [ACC_IW_L-1:0] acc_elem;
	logic [ACC_IW_L-1:0] acc_next;
	logic [7:0]  rd_byte;
	logic [15:0] add_a;
	logic [16:0] add_sum;
	logic        add_ov;

	assign opcode     = instr_q[16:10];
	assign an         = instr_q[9:8];
	assign imm8       = instr_q[7:0];
	assign idx_imm    = {instr_q[7:5], instr_q[10:8], instr_q[1:0]};
	assign idx_sel    = instr_q[4:2];
	assign is_maph    = opcode == mov_exec_pkg::OP_MAC_LOAD;
	assign is_maphs   = opcode == mov_exec_pkg::OP_MAC_LOAD_STR;
	assign is_bld     = opcode == mov_exec_pkg::OP_BYTE_LOAD;
	assign is_bst     = opcode == mov_exec_pkg::OP_BYTE_STORE;
	assign is_bsld    = opcode == mov_exec_pkg::OP_BSTR_LOAD;
	assign is_bsst    = opcode == mov_exec_pkg::OP_BSTR_STORE;
	assign is_acc_imm = opcode == mov_exec_pkg::OP_BYTE_ACC_IMM;
	assign is_mr_imm  = opcode == mov_exec_pkg::OP_BYTE_MR_IMM;
	assign is_idx_imm = instr_q[16:11] == mov_exec_pkg::OP_BYTE_IDX_IMM;
	assign is_str     = is_bsld | is_bsst;
	assign is_mem     = is_maph | is_maphs | is_bld | is_bst | is_str;
	assign instr_len  = (is_mem && needs_ext) ? mov_exec_pkg::LEN_LONG
	                                          : mov_exec_pkg::LEN_SHORT;
	operand_address_gen u_addr (
		.adrs_in       (instr_q[7:0]),
		.ext_word_in   (ext_q),
		.idx_in        (idx_q),
		.addr_out      (op_addr),
		.needs_ext_out (needs_ext)
	);
	assign acc_base = ACC_IW_L'({1'b0, an});
	assign acc_elem = acc_base + cnt_q;
	assign acc_next = acc_elem + ACC_IW_L'(1);
	assign mem_done = (state_q == mov_exec_pkg::ST_MEM) && dmem_ack_in;
	assign last_elem = !is_str || (cnt_q == str_len_q);
	// low byte at even byte address
	assign rd_byte = dmem_addr_q[0] ? dmem_rdata_in[15:8] : dmem_rdata_in[7:0];

	assign add_a   = is_maphs ? accumulator_n_q[acc_base + ACC_IW_L'(1)]
	                          : accumulator_n_q[acc_base];
	assign add_sum = {1'b0, add_a} + {1'b0, product_high_reg_q};
	assign add_ov  = (add_a[15] == product_high_reg_q[15]) && (add_sum[15] != add_a[15]);

	// bus: one wait state; architectural state only while idle
	logic bus_req;
	logic bus_grant;
	logic bus_do;
	logic arch_ofs;
	assign bus_req   = avs_read_in | avs_write_in;
	assign arch_ofs  = avs_address_in >= mov_exec_pkg::OFS_PC;
	assign bus_grant = !arch_ofs || (state_q == mov_exec_pkg::ST_IDLE);
	assign bus_do    = bus_req && bus_ack_q;
	assign avs_waitrequest_out = bus_req && !bus_ack_q;
	assign avs_readdata_out    = rdata_q;
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			bus_ack_q <= 1'b0;
			rdata_q   <= 32'h00000000;
		end else begin
			bus_ack_q <= bus_req && bus_grant && !bus_ack_q;
			if (bus_req && bus_grant && !bus_ack_q) begin
				rdata_q <= 32'h00000000;
				if (avs_address_in == mov_exec_pkg::OFS_CTRL) begin
					rdata_q[mov_exec_pkg::CTRL_RUN_BIT] <= run_q;
					rdata_q[mov_exec_pkg::CTRL_LEN_LSB +: mov_exec_pkg::CTRL_LEN_W] <= str_len_q;
				end else if (avs_address_in == mov_exec_pkg::OFS_STATUS) begin
					rdata_q[10:0] <= {illegal_q, state_q != mov_exec_pkg::ST_IDLE,
						ext_zero_flag_q, ext_sign_flag_q, aux_reg_zero_flag_q,
						aux_reg_carry_flag_q, carry_flag_q, zero_flag_q, sign_flag_q,
						overflow_flag_q, tag_flag_q};
				end else if (avs_address_in == mov_exec_pkg::OFS_PC) begin
					rdata_q[15:0] <= pc_q;
				end else if (avs_address_in == mov_exec_pkg::OFS_MR) begin
					rdata_q[15:0] <= multiplier_operand_reg_q;
				end else if (avs_address_in == mov_exec_pkg::OFS_PH) begin
					rdata_q[15:0] <= product_high_reg_q;
				end else if (avs_address_in[6:5] == 2'h1 && avs_address_in[1:0] == 2'h0) begin
					rdata_q[15:0] <= accumulator_n_q[avs_address_in[4:2]];
				end else if (avs_address_in[6:5] == 2'h2 && avs_address_in[1:0] == 2'h0) begin
					rdata_q[15:0] <= idx_q[avs_address_in[4:2]];
				end
			end
		end
	end
	// control register and sticky illegal opcode bit
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			run_q     <= 1'b0;
			str_len_q <= mov_exec_pkg::STR_LEN_RESET;
			illegal_q <= 1'b0;
		end else begin
			if (bus_do && avs_write_in && avs_address_in == mov_exec_pkg::OFS_CTRL) begin
				run_q     <= avs_writedata_in[mov_exec_pkg::CTRL_RUN_BIT];
				str_len_q <= avs_writedata_in[mov_exec_pkg::CTRL_LEN_LSB +: mov_exec_pkg::CTRL_LEN_W];
			end
			// set wins over write-one-to-clear
			if (state_q == mov_exec_pkg::ST_DECODE && !is_mem && !is_acc_imm &&
			    !is_mr_imm && !is_idx_imm) begin
				illegal_q <= 1'b1;
			end else if (bus_do && avs_write_in && avs_address_in == mov_exec_pkg::OFS_STATUS &&
			             avs_writedata_in[mov_exec_pkg::ST_ILL]) begin
				illegal_q <= 1'b0;
			end
		end
	end
	// sequencer, program counter and memory request registers
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			state_q      <= mov_exec_pkg::ST_IDLE;
			pc_q         <= mov_exec_pkg::PC_RESET;
			instr_q      <= 17'h00000;
			ext_q        <= 16'h0000;
			cnt_q        <= 3'h0;
			prog_addr_q  <= 16'h0000;
			dmem_addr_q  <= 16'h0000;
			dmem_wdata_q <= 8'h00;
		end else begin
			case (state_q)
				mov_exec_pkg::ST_IDLE: begin
					if (bus_do && avs_write_in && avs_address_in == mov_exec_pkg::OFS_PC) begin
						pc_q <= avs_writedata_in[15:0];
					end else if (run_q && !bus_req) begin
						prog_addr_q <= pc_q;
						state_q     <= mov_exec_pkg::ST_FETCH;
					end
				end
				mov_exec_pkg::ST_FETCH: begin
					if (prog_ack_in) begin
						instr_q <= prog_data_in;
						state_q <= mov_exec_pkg::ST_DECODE;
					end
				end
				mov_exec_pkg::ST_DECODE: begin
					cnt_q <= 3'h0;
					if (is_mem && needs_ext) begin
						prog_addr_q <= pc_q + 16'h0001;
						state_q     <= mov_exec_pkg::ST_EXT;
					end else if (is_mem) begin
						state_q <= mov_exec_pkg::ST_ADDR;
					end else begin
						state_q <= mov_exec_pkg::ST_DONE;
					end
				end
				mov_exec_pkg::ST_EXT: begin
					if (prog_ack_in) begin
						ext_q   <= prog_data_in[15:0];
						state_q <= mov_exec_pkg::ST_ADDR;
					end
				end
				mov_exec_pkg::ST_ADDR: begin
					dmem_addr_q  <= op_addr;
					dmem_wdata_q <= accumulator_n_q[acc_base][7:0];
					state_q      <= mov_exec_pkg::ST_MEM;
				end
				mov_exec_pkg::ST_MEM: begin
					if (dmem_ack_in) begin
						if (last_elem) begin
							state_q <= mov_exec_pkg::ST_DONE;
						end else begin
							cnt_q        <= cnt_q + 3'h1;
							dmem_addr_q  <= dmem_addr_q + 16'h0001;
							dmem_wdata_q <= accumulator_n_q[acc_next][7:0];
						end
					end
				end
				mov_exec_pkg::ST_DONE: begin
					pc_q    <= pc_q + instr_len;
					state_q <= mov_exec_pkg::ST_IDLE;
				end
				default: begin
					state_q <= mov_exec_pkg::ST_IDLE;
				end
			endcase
		end
	end
	assign prog_rd_out    = (state_q == mov_exec_pkg::ST_FETCH) || (state_q == mov_exec_pkg::ST_EXT);
	assign prog_addr_out  = prog_addr_q;
	assign dmem_req_out   = state_q == mov_exec_pkg::ST_MEM;
	assign dmem_we_out    = (state_q == mov_exec_pkg::ST_MEM) && (is_bst || is_bsst);
	assign dmem_addr_out  = dmem_addr_q;
	assign dmem_wdata_out = dmem_wdata_q;
	// accumulators
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < mov_exec_pkg::ACC_NUM; i++)
				accumulator_n_q[i] <= 16'h0000;
		end else begin
			if (bus_do && avs_write_in && avs_address_in[6:5] == 2'h1 &&
			    avs_address_in[1:0] == 2'h0) begin
				accumulator_n_q[avs_address_in[4:2]] <= avs_writedata_in[15:0];
			end else if (mem_done && is_maph) begin
				accumulator_n_q[acc_base] <= add_sum[15:0];
			end else if (mem_done && is_maphs) begin
				accumulator_n_q[acc_base + ACC_IW_L'(1)] <= add_sum[15:0];
			end else if (mem_done && is_bld) begin
				accumulator_n_q[acc_base] <= {8'h00, rd_byte};
			end else if (mem_done && is_bsld) begin
				accumulator_n_q[acc_elem] <= {8'h00, rd_byte};
			end else if (state_q == mov_exec_pkg::ST_DECODE && is_acc_imm) begin
				accumulator_n_q[acc_base] <= {8'h00, imm8};
			end
		end
	end
	// multiplier operand, product high and index registers
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			multiplier_operand_reg_q <= 16'h0000;
			product_high_reg_q       <= 16'h0000;
			idx_q                    <= '0;
		end else begin
			if (bus_do && avs_write_in && avs_address_in == mov_exec_pkg::OFS_MR) begin
				multiplier_operand_reg_q <= avs_writedata_in[15:0];
			end else if (mem_done && (is_maph || is_maphs)) begin
				multiplier_operand_reg_q <= dmem_rdata_in[15:0];
			end else if (state_q == mov_exec_pkg::ST_DECODE && is_mr_imm) begin
				multiplier_operand_reg_q <= {8'h00, imm8};
			end
			if (bus_do && avs_write_in && avs_address_in == mov_exec_pkg::OFS_PH) begin
				product_high_reg_q <= avs_writedata_in[15:0];
			end
			if (bus_do && avs_write_in && avs_address_in[6:5] == 2'h2 &&
			    avs_address_in[1:0] == 2'h0) begin
				idx_q[avs_address_in[4:2]] <= avs_writedata_in[15:0];
			end else if (state_q == mov_exec_pkg::ST_DECODE && is_idx_imm) begin
				idx_q[idx_sel] <= {8'h00, idx_imm};
			end
		end
	end

	// status flags; the operand register immediate form touches none
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			{tag_flag_q, overflow_flag_q, sign_flag_q, zero_flag_q, carry_flag_q} <= 5'h00;
			{aux_reg_carry_flag_q, aux_reg_zero_flag_q, ext_sign_flag_q, ext_zero_flag_q} <= 4'h0;
		end else if (mem_done && (is_maph || is_maphs)) begin
			tag_flag_q      <= dmem_rdata_in[mov_exec_pkg::TAG_BIT];
			overflow_flag_q <= add_ov;
			sign_flag_q     <= add_sum[15];
			zero_flag_q     <= add_sum[15:0] == 16'h0000;
			carry_flag_q    <= add_sum[16];
		end else if (mem_done && (is_bld || is_bsld)) begin
			tag_flag_q      <= dmem_rdata_in[mov_exec_pkg::TAG_BIT];
			overflow_flag_q <= 1'b0;
			sign_flag_q     <= 1'b0;
			carry_flag_q    <= 1'b0;
			zero_flag_q     <= (rd_byte == 8'h00) && (cnt_q == 3'h0 || zero_flag_q);
		end else if (mem_done && (is_bst || is_bsst)) begin
			ext_sign_flag_q <= dmem_wdata_q[7];
			ext_zero_flag_q <= (dmem_wdata_q == 8'h00) && (cnt_q == 3'h0 || ext_zero_flag_q);
		end else if (state_q == mov_exec_pkg::ST_DECODE && is_acc_imm) begin
			overflow_flag_q <= 1'b0;
			sign_flag_q     <= 1'b0;
			carry_flag_q    <= 1'b0;
			zero_flag_q     <= imm8 == 8'h00;
		end else if (state_q == mov_exec_pkg::ST_DECODE && is_idx_imm) begin
			aux_reg_carry_flag_q <= 1'b0;
			aux_reg_zero_flag_q  <= idx_imm == 8'h00;
		end
	end

endmodule // byte_move_and_mac_load_exec

// *** test/exec_asserts.sv ***
// port-level checks on the byte move / multiply load executor
`timescale 1ns/1ps
module exec_asserts (
	input wire logic        clk_sys_in,
	input wire logic        rst_in,
	input wire logic [6:0]  avs_address_in,
	input wire logic        avs_read_in,
	input wire logic        avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic        avs_waitrequest_out,
	input wire logic        prog_rd_out,
	input wire logic [15:0] prog_addr_out,
	input wire logic [16:0] prog_data_in,
	input wire logic        prog_ack_in,
	input wire logic        dmem_req_out,
	input wire logic        dmem_we_out,
	input wire logic [15:0] dmem_addr_out,
	input wire logic [7:0]  dmem_wdata_out,
	input wire logic [16:0] dmem_rdata_in,
	input wire logic        dmem_ack_in
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	logic [15:0] ext_addr_q;
	logic        is_mem;
	assign is_mem = prog_data_in[16:10] inside {mov_exec_pkg::OP_MAC_LOAD,
		mov_exec_pkg::OP_MAC_LOAD_STR, mov_exec_pkg::OP_BYTE_LOAD, mov_exec_pkg::OP_BYTE_STORE,
		mov_exec_pkg::OP_BSTR_LOAD, mov_exec_pkg::OP_BSTR_STORE};
	// where the second instruction word must be read from
	always_ff @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in)
			ext_addr_q <= 16'h0000;
		else if (prog_ack_in)
			ext_addr_q <= prog_addr_out + 16'h0001;
	end
	a_idle_no_wait: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
		else $error("waitrequest high with no request");
	a_ctrl_one_wait: assert property ($rose(avs_write_in) && avs_address_in ==
		mov_exec_pkg::OFS_CTRL |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
		else $error("control write not answered after one wait");
	a_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out &&
		avs_address_in == 7'h7C |-> avs_readdata_out == 32'h00000000)
		else $error("unmapped read not zero");
	a_prog_hold: assert property (prog_rd_out && !prog_ack_in |=>
		prog_rd_out && $stable(prog_addr_out)) else $error("program request dropped early");
	a_dmem_hold: assert property (dmem_req_out && !dmem_ack_in |=> dmem_req_out &&
		$stable(dmem_addr_out) && $stable(dmem_we_out) && $stable(dmem_wdata_out))
		else $error("data request changed before ack");
	a_store_with_req: assert property (dmem_we_out |-> dmem_req_out)
		else $error("store strobe without request");
	a_ext_word_fetch: assert property (prog_ack_in && prog_rd_out && is_mem &&
		!prog_data_in[7] |-> ##[1:4] (prog_rd_out && prog_addr_out == ext_addr_q))
		else $error("second instruction word not fetched");
	a_string_step: assert property (dmem_req_out && dmem_ack_in ##1 dmem_req_out |->
		dmem_addr_out == $past(dmem_addr_out) + 16'h0001)
		else $error("string element address not advanced by one");
endmodule // exec_asserts

bind byte_move_and_mac_load_exec exec_asserts u_exec_asserts (
	.clk_sys_in(clk_sys_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
	.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
	.avs_waitrequest_out(avs_waitrequest_out), .prog_rd_out(prog_rd_out),
	.prog_addr_out(prog_addr_out), .prog_data_in(prog_data_in), .prog_ack_in(prog_ack_in),
	.dmem_req_out(dmem_req_out), .dmem_we_out(dmem_we_out), .dmem_addr_out(dmem_addr_out),
	.dmem_wdata_out(dmem_wdata_out), .dmem_rdata_in(dmem_rdata_in), .dmem_ack_in(dmem_ack_in)
);

// *** test/data_mem_model.sv ***
// behavioural program and data memory facing the executor
`timescale 1ns/1ps
module data_mem_model (
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        prog_rd_in,
	input  wire logic [15:0] prog_addr_in,
	output logic      [16:0] prog_data_out,
	output logic             prog_ack_out,
	input  wire logic        dmem_req_in,
	input  wire logic        dmem_we_in,
	input  wire logic [15:0] dmem_addr_in,
	input  wire logic [7:0]  dmem_wdata_in,
	output logic      [16:0] dmem_rdata_out,
	output logic             dmem_ack_out
);
	logic [16:0] prog [0:63];
	logic [16:0] dmem [0:255];
	int          lat = 0;
	int          cnt_p;
	int          cnt_d;
	// answer after lat cycles; between answers the data lines toggle
	always @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prog_ack_out <= 1'b0;
			dmem_ack_out <= 1'b0;
			prog_data_out <= 17'h00000;
			dmem_rdata_out <= 17'h00000;
			cnt_p <= 0;
			cnt_d <= 0;
		end else begin
			prog_ack_out <= 1'b0;
			dmem_ack_out <= 1'b0;
			prog_data_out <= ~prog_data_out;
			dmem_rdata_out <= ~dmem_rdata_out;
			cnt_p <= (prog_rd_in && !prog_ack_out) ? cnt_p + 1 : 0;
			cnt_d <= (dmem_req_in && !dmem_ack_out) ? cnt_d + 1 : 0;
			if (prog_rd_in && !prog_ack_out && cnt_p >= lat) begin
				prog_ack_out <= 1'b1;
				prog_data_out <= prog[prog_addr_in[5:0]];
			end
			if (dmem_req_in && !dmem_ack_out && cnt_d >= lat) begin
				dmem_ack_out <= 1'b1;
				dmem_rdata_out <= dmem[dmem_addr_in[8:1]];
				if (dmem_we_in && dmem_addr_in[0])
					dmem[dmem_addr_in[8:1]][15:8] <= dmem_wdata_in;
				else if (dmem_we_in)
					dmem[dmem_addr_in[8:1]][7:0] <= dmem_wdata_in;
			end
		end
	end
endmodule // data_mem_model

// *** test/byte_move_and_mac_load_exec_tb.sv ***
// self-checking bench for the byte move / multiply load executor
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module byte_move_and_mac_load_exec_tb;
	logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
	logic [6:0]  adr = 7'h00;
	logic [31:0] wdat = 32'h00000000, rdat, s, s2, v;
	logic        wreq, p_rd, p_ack, d_req, d_we, d_ack;
	logic [15:0] p_adr, d_adr;
	logic [16:0] p_dat, d_rdat;
	logic [7:0]  d_wdat;
	int          n_mismatch = 0, n_compared = 0;
	byte_move_and_mac_load_exec uut (.clk_sys_in(clk), .rst_in(rst), .avs_address_in(adr),
		.avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
		.avs_waitrequest_out(wreq), .prog_rd_out(p_rd), .prog_addr_out(p_adr),
		.prog_data_in(p_dat), .prog_ack_in(p_ack), .dmem_req_out(d_req), .dmem_we_out(d_we),
		.dmem_addr_out(d_adr), .dmem_wdata_out(d_wdat), .dmem_rdata_in(d_rdat),
		.dmem_ack_in(d_ack));
	data_mem_model mem (.clk_in(clk), .rst_in(rst), .prog_rd_in(p_rd), .prog_addr_in(p_adr),
		.prog_data_out(p_dat), .prog_ack_out(p_ack), .dmem_req_in(d_req), .dmem_we_in(d_we),
		.dmem_addr_in(d_adr), .dmem_wdata_in(d_wdat), .dmem_rdata_out(d_rdat),
		.dmem_ack_out(d_ack));
	initial forever #12.5 clk = ~clk;
	task automatic reg_wr(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wdat <= d;
		wr <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [6:0] a, output logic [31:0] d);
		@(posedge clk);
		adr <= a;
		rd <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		d = rdat;
		rd <= 1'b0;
	endtask
	task automatic expect_reg(input logic [6:0] a, input logic [31:0] e);
		reg_rd(a, v);
		`CHK(v, e)
	endtask
	task automatic st();
		reg_rd(mov_exec_pkg::OFS_STATUS, s);
	endtask
	function automatic logic [6:0] acc_a(input int k);
		return mov_exec_pkg::OFS_ACC0 + 7'(4 * k);
	endfunction
	function automatic logic [6:0] idx_a(input int k);
		return mov_exec_pkg::OFS_IDX0 + 7'(4 * k);
	endfunction
	// one instruction: run raised then dropped, so the executor idles after it
	task automatic run(input logic [15:0] pc, input logic [16:0] w0, w1,
			input logic [2:0] len, input logic [15:0] pc_exp);
		mem.prog[pc[5:0]] = w0;
		mem.prog[pc[5:0] + 6'h01] = w1;
		reg_wr(mov_exec_pkg::OFS_PC, {16'h0000, pc});
		reg_wr(mov_exec_pkg::OFS_CTRL, {25'h0000000, len, 4'h1});
		reg_wr(mov_exec_pkg::OFS_CTRL, {25'h0000000, len, 4'h0});
		expect_reg(mov_exec_pkg::OFS_PC, {16'h0000, pc_exp});
	endtask
	task automatic finish_test();
		$display("compared %0d, mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		finish_test();
	end
	// no background interrupt service runs around the string form
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		expect_reg(mov_exec_pkg::OFS_CTRL, 32'h00000010);
		st();
		`CHK(s, 32'h00000000)
		reg_wr(7'h7C, 32'hFFFFFFFF);
		expect_reg(7'h7C, 32'h00000000);
		// slow memory, direct address
		mem.lat = 3;
		mem.dmem[8'h10] = 17'h11234;
		reg_wr(acc_a(1), 32'h00007FFF);
		reg_wr(mov_exec_pkg::OFS_PH, 32'h00000001);
		run(16'h0010, 17'h0D100, 17'h00020, 3'h1, 16'h0012);
		expect_reg(mov_exec_pkg::OFS_MR, 32'h00001234);
		expect_reg(acc_a(1), 32'h00008000);
		st();
		`CHK(s[4:1], 4'h3)
		// prompt memory, indirect, string form
		mem.lat = 0;
		mem.dmem[8'h11] = 17'h000AB;
		reg_wr(idx_a(0), 32'h00000022);
		reg_wr(acc_a(2), 32'h00005555);
		reg_wr(acc_a(3), 32'h0000FFFF);
		run(16'h0020, 17'h0D680, 17'h00000, 3'h1, 16'h0021);
		expect_reg(mov_exec_pkg::OFS_MR, 32'h000000AB);
		expect_reg(acc_a(3), 32'h00000000);
		expect_reg(acc_a(2), 32'h00005555);
		st();
		`CHK(s[4:1], 4'hC)
		s2 = s;
		run(16'h0028, 17'h15C22, 17'h00000, 3'h1, 16'h0029);
		expect_reg(mov_exec_pkg::OFS_MR, 32'h00000022);
		st();
		`CHK(s, s2)
		// register-relative byte load from the odd byte
		mem.dmem[8'h12] = 17'h09C5A;
		reg_wr(idx_a(1), 32'h00000020);
		reg_wr(idx_a(2), 32'h00000005);
		reg_wr(acc_a(0), 32'h0000FFFF);
		run(16'h0030, 17'h098CA, 17'h00000, 3'h1, 16'h0031);
		expect_reg(acc_a(0), 32'h0000009C);
		st();
		`CHK(s[4:1], 4'h0)
		// long-relative byte store into a high lane
		mem.dmem[8'h18] = 17'h11111;
		reg_wr(idx_a(3), 32'h00000030);
		reg_wr(acc_a(0), 32'h0000ABCD);
		run(16'h0040, 17'h0A043, 17'h00001, 3'h1, 16'h0042);
		`CHK(mem.dmem[8'h18], 17'h1CD11)
		st();
		`CHK(s[8:7], 2'h1)
		reg_wr(acc_a(3), 32'h0000FFFF);
		run(16'h0050, 17'h14780, 17'h00000, 3'h1, 16'h0051);
		expect_reg(acc_a(3), 32'h00000080);
		reg_wr(idx_a(4), 32'h00001234);
		run(16'h0060, 17'h17010, 17'h00000, 3'h1, 16'h0061);
		expect_reg(idx_a(4), 32'h00000000);
		st();
		`CHK(s[6:5], 2'h2)
		// two-byte string across a word boundary, then stored back
		mem.dmem[8'h20] = 17'h07700;
		mem.dmem[8'h21] = 17'h10066;
		run(16'h0070, 17'h09E00, 17'h00041, 3'h1, 16'h0072);
		expect_reg(acc_a(2), 32'h00000077);
		expect_reg(acc_a(3), 32'h00000066);
		st();
		`CHK({s[3], s[0]}, 2'h1)
		mem.dmem[8'h28] = 17'h10000;
		run(16'h0078, 17'h0A600, 17'h00050, 3'h1, 16'h007A);
		`CHK(mem.dmem[8'h28], 17'h16677)
		st();
		`CHK(s[8:7], 2'h0)
		// undecoded opcode: sticky illegal bit, one-word step, write one clears
		run(16'h0080, 17'h00000, 17'h00000, 3'h1, 16'h0081);
		st();
		`CHK(s[10], 1'b1)
		reg_wr(mov_exec_pkg::OFS_STATUS, 32'h00000400);
		st();
		`CHK(s[10], 1'b0)
		finish_test();
	end
endmodule // byte_move_and_mac_load_exec_tb
